/* File: hw/hcp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module hcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* File: hw/hcp_pkg.sv */
// Constants and types for the host communication port controller.
// Assumes a single 10 MHz system clock and a 32-bit Avalon-MM register bus.
package hcp_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam logic [11:0] DIV_4800 = 12'(CLK_HZ / 4800);
  localparam logic [11:0] DIV_9600 = 12'(CLK_HZ / 9600);
  localparam logic [11:0] DIV_19200 = 12'(CLK_HZ / 19200);
  localparam logic [11:0] DIV_38400 = 12'(CLK_HZ / 38400);
  localparam logic [11:0] DIV_115200 = 12'(CLK_HZ / 115200);
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  // ****************
  // Register map
  // ****************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_BAUD = 5'h04;
  localparam logic [4:0] OFS_ADDR = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_CMD = 5'h10;
  localparam logic [4:0] OFS_TXD = 5'h14;
  localparam logic [4:0] OFS_RXD = 5'h18;
  localparam int CTRL_IF_LSB = 0;
  localparam int CTRL_USB_KBD = 2;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_EXT_EXTERNAL_TRIGGER_INPUT = 4;
  localparam int CTRL_EDGE_OFF = 5;
  localparam int CTRL_CRLF = 6;
  localparam int CMD_LOCAL = 0;
  localparam logic [1:0] IF_USB = 2'h0;
  localparam logic [1:0] IF_SER = 2'h1;
  localparam logic [1:0] IF_BUS = 2'h2;
  localparam logic [1:0] IF_RST = IF_USB;
  localparam logic [2:0] BAUD_RST = 3'h1;
  localparam logic [2:0] BAUD_MAX = 3'h4;
  localparam logic [4:0] ADDR_RST = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} hcp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} hcp_rx_state_type;
endpackage

/* File: hw/hcp_top.sv */
// Host communication port controller: interface selection, serial port,
// automatic measured-value output, trigger edge detection and remote/local state.
// Assumes all inputs synchronous to SYS_CLK_IN; activity inputs are one-cycle pulses.
`timescale 1ns/1ps
// Behaviour
// - Only the selected host interface is enabled; others stay inactive.
// - Serial baud selectable 4800/9600/19200/38400/115200, default 9600.
// - RTS and DTR held on; DCD, DSR, CTS and RI ignored.
// - Bus device address settable 0 to 30, default 1.
// - Bus delimiter LF or CR+LF, default LF.
// - USB offers keyboard mode or command control mode, the default.
// - With auto output on, serial/USB only sends values, accepts no commands.
// - External trigger mode sends a value per trigger or enter key.
// - Internal trigger mode sends newest value at each measurement end.
// - Any host communication enters remote state, shown by remote indicator.
// - In remote state all keys except local are ignored.
// - Entering remote with menu shown switches to measurement screen.
// - Local key, power cycle, local command or bus go-to-local end remote.
// - External trigger starts measurement on selected edge, on edge default.
module hcp_top (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic [4:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  output logic USB_EN_OUT,
  output logic SER_EN_OUT,
  output logic BUS_EN_OUT,
  input wire logic USB_ACT_IN,
  input wire logic BUS_ACT_IN,
  input wire logic BUS_GTL_IN,
  output logic [4:0] BUS_ADDR_OUT,
  output logic DELIM_CRLF_OUT,
  output logic USB_KBD_MODE_OUT,
  output logic [7:0] HOST_TX_DATA_OUT,
  output logic HOST_TX_VALID_OUT,
  input wire logic HOST_TX_READY_IN,
  input wire logic SER_RXD_IN,
  output logic SER_TXD_OUT,
  output logic SER_RTS_OUT,
  output logic SER_DTR_OUT,
  input wire logic EXTERNAL_TRIGGER_INPUT_IN,
  input wire logic [7:0] MEAS_DATA_IN,
  input wire logic MEAS_DONE_IN,
  output logic MEAS_START_OUT,
  input wire logic [7:0] KEY_IN,
  input wire logic KEY_ENTER_IN,
  input wire logic KEY_LOCAL_IN,
  output logic [7:0] KEY_OUT,
  input wire logic MENU_SHOWN_IN,
  output logic SHOW_MEAS_OUT,
  output logic REMOTE_INDICATOR_OUT
);
  // ****************
  // Configuration
  // ****************
  logic [1:0] if_sel_reg;
  logic usb_kbd_reg;
  logic auto_reg;
  logic ext_external_trigger_input_reg;
  logic edge_off_reg;
  logic crlf_reg;
  logic [2:0] baud_reg;
  logic [4:0] addr_reg;
  logic remote_reg;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;
  logic [7:0] last_meas_reg;
  logic external_trigger_input_prev_reg;
  logic bus_ack;
  logic wr_ok;
  logic rd_ok;
  logic auto_act;
  logic external_trigger_input_edge;
  logic auto_push;
  logic sw_push;
  logic local_cmd;
  logic host_act;
  logic rx_byte;
  logic [7:0] rx_shift_reg;
  logic [11:0] div_sel;
  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_in_data;
  logic tx_take;
  logic host_take;

  assign wr_ok = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  assign rd_ok = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  // Auto output owns serial or USB; keyboard mode is auto output by nature
  // keyboard mode output
  assign auto_act = (if_sel_reg == hcp_pkg::IF_SER && auto_reg) ||
                    (if_sel_reg == hcp_pkg::IF_USB && (auto_reg || usb_kbd_reg));
  assign local_cmd = wr_ok && AVS_ADDRESS_IN == hcp_pkg::OFS_CMD &&
                     AVS_WRITEDATA_IN[hcp_pkg::CMD_LOCAL];
  assign sw_push = wr_ok && AVS_ADDRESS_IN == hcp_pkg::OFS_TXD && !auto_act;
  assign external_trigger_input_edge = edge_off_reg ? (external_trigger_input_prev_reg && !EXTERNAL_TRIGGER_INPUT_IN)
                                  : (!external_trigger_input_prev_reg && EXTERNAL_TRIGGER_INPUT_IN);

  always_comb
  begin
    auto_push = 1'b0;
    fifo_in_data = AVS_WRITEDATA_IN[7:0];
    if (auto_act)
    begin
      if (ext_external_trigger_input_reg)
      begin
        auto_push = external_trigger_input_edge || (KEY_ENTER_IN && !remote_reg);
        fifo_in_data = last_meas_reg;
      end
      else
      begin
        auto_push = MEAS_DONE_IN;
        fifo_in_data = MEAS_DATA_IN;
      end
    end
  end

  // ****************
  // Avalon-MM slave
  // ****************
  // One idle wait cycle per access; TXD writes outside auto output also wait while the FIFO is full
  assign bus_ack = (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT &&
                   !(AVS_WRITE_IN && AVS_ADDRESS_IN == hcp_pkg::OFS_TXD &&
                     !auto_act && !fifo_in_ready);

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT <= 32'h00000000;
    end
    else
    begin
      AVS_WAITREQUEST_OUT <= !bus_ack;
      if (bus_ack && AVS_READ_IN)
      begin
        unique case (AVS_ADDRESS_IN)
          hcp_pkg::OFS_CTRL: AVS_READDATA_OUT <= {25'h0, crlf_reg, edge_off_reg,
                                                  ext_external_trigger_input_reg, auto_reg, usb_kbd_reg,
                                                  if_sel_reg};
          hcp_pkg::OFS_BAUD: AVS_READDATA_OUT <= {29'h0, baud_reg};
          hcp_pkg::OFS_ADDR: AVS_READDATA_OUT <= {27'h0, addr_reg};
          hcp_pkg::OFS_STAT: AVS_READDATA_OUT <= {27'h0, auto_act, !fifo_out_valid,
                                                  !fifo_in_ready, rx_valid_reg, remote_reg};
          hcp_pkg::OFS_RXD: AVS_READDATA_OUT <= {24'h0, rx_data_reg};
          default: AVS_READDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration writes; out-of-range codes are ignored
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      if_sel_reg <= hcp_pkg::IF_RST;
      usb_kbd_reg <= 1'b0;
      auto_reg <= 1'b0;
      ext_external_trigger_input_reg <= 1'b0;
      edge_off_reg <= 1'b0;
      crlf_reg <= 1'b0;
      baud_reg <= hcp_pkg::BAUD_RST;
      addr_reg <= hcp_pkg::ADDR_RST;
    end
    else if (wr_ok)
    begin
      if (AVS_ADDRESS_IN == hcp_pkg::OFS_CTRL)
      begin
        if (AVS_WRITEDATA_IN[hcp_pkg::CTRL_IF_LSB +: 2] <= hcp_pkg::IF_BUS)
        begin
          if_sel_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_IF_LSB +: 2];
        end
        usb_kbd_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_USB_KBD];
        auto_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_AUTO];
        ext_external_trigger_input_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_EXT_EXTERNAL_TRIGGER_INPUT];
        edge_off_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_EDGE_OFF];
        crlf_reg <= AVS_WRITEDATA_IN[hcp_pkg::CTRL_CRLF];
      end
      if (AVS_ADDRESS_IN == hcp_pkg::OFS_BAUD && AVS_WRITEDATA_IN[2:0] <= hcp_pkg::BAUD_MAX)
      begin
        baud_reg <= AVS_WRITEDATA_IN[2:0];
      end
      if (AVS_ADDRESS_IN == hcp_pkg::OFS_ADDR && AVS_WRITEDATA_IN[4:0] <= hcp_pkg::ADDR_MAX)
      begin
        addr_reg <= AVS_WRITEDATA_IN[4:0];
      end
    end
  end

  // ****************
  // Interface enables and static pins
  // ****************
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      USB_EN_OUT <= 1'b0;
      SER_EN_OUT <= 1'b0;
      BUS_EN_OUT <= 1'b0;
      BUS_ADDR_OUT <= hcp_pkg::ADDR_RST;
      DELIM_CRLF_OUT <= 1'b0;
      USB_KBD_MODE_OUT <= 1'b0;
      SER_RTS_OUT <= 1'b1;
      SER_DTR_OUT <= 1'b1;
    end
    else
    begin
      USB_EN_OUT <= (if_sel_reg == hcp_pkg::IF_USB);
      SER_EN_OUT <= (if_sel_reg == hcp_pkg::IF_SER);
      BUS_EN_OUT <= (if_sel_reg == hcp_pkg::IF_BUS);
      BUS_ADDR_OUT <= addr_reg;
      DELIM_CRLF_OUT <= crlf_reg;
      USB_KBD_MODE_OUT <= usb_kbd_reg;
      SER_RTS_OUT <= 1'b1;
      SER_DTR_OUT <= 1'b1;
    end
  end

  // ****************
  // Output FIFO and host stream
  // ****************
  hcp_fifo #(
    .WIDTH(hcp_pkg::FIFO_WIDTH),
    .DEPTH(hcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .in_data_in(fifo_in_data),
    .in_valid_in(auto_push || sw_push),
    .in_ready_out(fifo_in_ready),
    .out_data_out(fifo_out_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready)
  );

  assign host_take = (if_sel_reg != hcp_pkg::IF_SER) &&
                     (!HOST_TX_VALID_OUT || HOST_TX_READY_IN);
  assign fifo_out_ready = tx_take || host_take;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      HOST_TX_VALID_OUT <= 1'b0;
      HOST_TX_DATA_OUT <= 8'h00;
    end
    else if (host_take)
    begin
      HOST_TX_VALID_OUT <= fifo_out_valid;
      HOST_TX_DATA_OUT <= fifo_out_data;
    end
  end

  // ****************
  // Serial port, 8N1 without flow control
  // ****************
  hcp_pkg::hcp_tx_state_type tx_state_reg;
  hcp_pkg::hcp_rx_state_type rx_state_reg;
  logic [11:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_shift_reg;
  logic [11:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;

  always_comb
  begin
    unique case (baud_reg)
      3'h0: div_sel = hcp_pkg::DIV_4800;
      3'h2: div_sel = hcp_pkg::DIV_19200;
      3'h3: div_sel = hcp_pkg::DIV_38400;
      3'h4: div_sel = hcp_pkg::DIV_115200;
      default: div_sel = hcp_pkg::DIV_9600;
    endcase
  end

  assign tx_take = (if_sel_reg == hcp_pkg::IF_SER) && tx_state_reg == hcp_pkg::TX_IDLE;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      tx_state_reg <= hcp_pkg::TX_IDLE;
      tx_cnt_reg <= 12'h000;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 10'h3FF;
      SER_TXD_OUT <= 1'b1;
    end
    else
    begin
      unique case (tx_state_reg)
        hcp_pkg::TX_IDLE:
        begin
          SER_TXD_OUT <= 1'b1;
          if (tx_take && fifo_out_valid)
          begin
            tx_shift_reg <= {1'b1, fifo_out_data, 1'b0};
            tx_cnt_reg <= div_sel;
            tx_bit_reg <= 4'h0;
            tx_state_reg <= hcp_pkg::TX_BUSY;
          end
        end
        hcp_pkg::TX_BUSY:
        begin
          SER_TXD_OUT <= tx_shift_reg[0];
          if (tx_cnt_reg == 12'h001)
          begin
            tx_cnt_reg <= div_sel;
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == hcp_pkg::UART_LAST_BIT)
            begin
              tx_state_reg <= hcp_pkg::TX_IDLE;
            end
          end
          else
          begin
            tx_cnt_reg <= tx_cnt_reg - 12'h001;
          end
        end
      endcase
    end
  end

  // Receiver samples mid-bit; a low stop bit drops the byte
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      rx_state_reg <= hcp_pkg::RX_IDLE;
      rx_cnt_reg <= 12'h000;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
    end
    else
    begin
      unique case (rx_state_reg)
        hcp_pkg::RX_IDLE:
        begin
          if (SER_EN_OUT && !SER_RXD_IN)
          begin
            rx_cnt_reg <= {1'b0, div_sel[11:1]};
            rx_bit_reg <= 4'h0;
            rx_state_reg <= hcp_pkg::RX_RECV;
          end
        end
        hcp_pkg::RX_RECV:
        begin
          if (rx_cnt_reg == 12'h000)
          begin
            // Zero count is a cycle of its own, so reload one short of a bit time
            rx_cnt_reg <= div_sel - 12'h001;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg != 4'h0 && rx_bit_reg != hcp_pkg::UART_LAST_BIT)
            begin
              rx_shift_reg <= {SER_RXD_IN, rx_shift_reg[7:1]};
            end
            if ((rx_bit_reg == 4'h0 && SER_RXD_IN) || rx_bit_reg == hcp_pkg::UART_LAST_BIT)
            begin
              rx_state_reg <= hcp_pkg::RX_IDLE;
            end
          end
          else
          begin
            rx_cnt_reg <= rx_cnt_reg - 12'h001;
          end
        end
      endcase
    end
  end

  assign rx_byte = rx_state_reg == hcp_pkg::RX_RECV && rx_cnt_reg == 12'h000 &&
                   rx_bit_reg == hcp_pkg::UART_LAST_BIT && SER_RXD_IN;

  // no commands while auto output; new byte wins over read clear
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end
    else if (rx_byte && !auto_act)
    begin
      rx_valid_reg <= 1'b1;
      rx_data_reg <= rx_shift_reg;
    end
    else if (rd_ok && AVS_ADDRESS_IN == hcp_pkg::OFS_RXD)
    begin
      rx_valid_reg <= 1'b0;
    end
  end

  // ****************
  // Trigger and measurement
  // ****************
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      external_trigger_input_prev_reg <= 1'b0;
      last_meas_reg <= 8'h00;
      MEAS_START_OUT <= 1'b0;
    end
    else
    begin
      external_trigger_input_prev_reg <= EXTERNAL_TRIGGER_INPUT_IN;
      MEAS_START_OUT <= ext_external_trigger_input_reg && external_trigger_input_edge;
      if (MEAS_DONE_IN)
      begin
        last_meas_reg <= MEAS_DATA_IN;
      end
    end
  end

  // ****************
  // Remote and local state
  // ****************
  // activity on the enabled interface
  assign host_act = (USB_ACT_IN && USB_EN_OUT) || (BUS_ACT_IN && BUS_EN_OUT) || rx_byte;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      remote_reg <= 1'b0;
      REMOTE_INDICATOR_OUT <= 1'b0;
      SHOW_MEAS_OUT <= 1'b0;
      KEY_OUT <= 8'h00;
    end
    else
    begin
      if (host_act)
      begin
        remote_reg <= 1'b1;
      end
      else if (KEY_LOCAL_IN || local_cmd || (BUS_GTL_IN && BUS_EN_OUT))
      begin
        remote_reg <= 1'b0;
      end
      REMOTE_INDICATOR_OUT <= host_act || (remote_reg &&
                              !(KEY_LOCAL_IN || local_cmd || (BUS_GTL_IN && BUS_EN_OUT)));
      SHOW_MEAS_OUT <= host_act && !remote_reg && MENU_SHOWN_IN;
      KEY_OUT <= remote_reg ? 8'h00 : KEY_IN;
    end
  end

  // ****************
  // Checks
  // ****************
  a_single_iface: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    $onehot0({USB_EN_OUT, SER_EN_OUT, BUS_EN_OUT}))
    else $error("more than one host interface enabled");
  a_baud_code: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    baud_reg <= hcp_pkg::BAUD_MAX)
    else $error("baud code out of range");
  a_handshake_on: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    SER_RTS_OUT && SER_DTR_OUT)
    else $error("RTS or DTR dropped");
  a_addr_range: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    BUS_ADDR_OUT <= hcp_pkg::ADDR_MAX)
    else $error("bus address above 30");
  a_auto_no_rx: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    auto_act && !rx_valid_reg |=> !rx_valid_reg)
    else $error("command byte accepted during auto output");
  a_int_push: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    auto_act && !ext_external_trigger_input_reg && MEAS_DONE_IN && !fifo_out_valid
    |=> fifo_out_valid && fifo_out_data == $past(MEAS_DATA_IN))
    else $error("measurement not queued");
  a_remote_entry: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    host_act |=> remote_reg && REMOTE_INDICATOR_OUT ##1 KEY_OUT == 8'h00)
    else $error("remote not entered after activity");
  a_keys_locked: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    remote_reg |=> KEY_OUT == 8'h00)
    else $error("key passed in remote state");
  a_menu_exit: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    host_act && !remote_reg && MENU_SHOWN_IN |=> SHOW_MEAS_OUT ##1 !SHOW_MEAS_OUT)
    else $error("measurement screen not forced");
  a_local_exit: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    KEY_LOCAL_IN && !host_act |=> !remote_reg && !REMOTE_INDICATOR_OUT)
    else $error("local key did not end remote");
  a_external_trigger_input_start: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    ext_external_trigger_input_reg && !edge_off_reg && $rose(EXTERNAL_TRIGGER_INPUT_IN) |=> MEAS_START_OUT)
    else $error("no start on trigger on edge");
  c_serial_byte: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) rx_byte);
  c_fifo_full: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) !fifo_in_ready);
  c_remote_local: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    remote_reg ##[1:50] !remote_reg);
endmodule

/* File: test/hcp_host_model.sv */
// Host controller model on the serial link of the port controller.
// Assumes tasks are called right after a rising edge of clk_in.
`timescale 1ns/1ps
module hcp_host_model (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out
);
  // Idle line rests high between frames
  initial rxd_out = 1'b1;
  task automatic send_byte(input logic [7:0] b, input int bit_cycles);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out <= f[i];
      repeat (bit_cycles) @(posedge clk_in);
    end
  endtask
  task automatic recv_byte(input int bit_cycles, output logic [7:0] b);
    while (txd_in !== 1'b0) @(posedge clk_in);
    repeat (bit_cycles + bit_cycles / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = txd_in;
      repeat (bit_cycles) @(posedge clk_in);
    end
  endtask
endmodule

/* File: test/tb_host_command_control_mode_port_control.sv */
// Self-checking bench for the host port controller.
// Assumes the host model and design files are compiled first.
`timescale 1ns/1ps
module tb_host_command_control_mode_port_control;
  logic clk, rst, rd_s, wr_s, usb_act, bus_act, gtl, external_trigger_input, done, kent, kloc, menu, rdy;
  logic [4:0] adr;
  logic [31:0] wd, rdat;
  logic [7:0] md, key, b;
  logic [7:0] got[$];
  int error_cnt, checks, starts, i, n, bc;
  wire logic [31:0] rdo;
  wire logic [4:0] ba;
  wire logic [7:0] txdat, ko;
  wire logic wrq, ue, se, be, dl, kb, txv, txd, rxd, rts, dtr, mst, shw, rem;
  hcp_top DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd_s),
    .AVS_WRITE_IN(wr_s), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdo),
    .AVS_WAITREQUEST_OUT(wrq), .USB_EN_OUT(ue), .SER_EN_OUT(se), .BUS_EN_OUT(be),
    .USB_ACT_IN(usb_act), .BUS_ACT_IN(bus_act), .BUS_GTL_IN(gtl), .BUS_ADDR_OUT(ba),
    .DELIM_CRLF_OUT(dl), .USB_KBD_MODE_OUT(kb), .HOST_TX_DATA_OUT(txdat),
    .HOST_TX_VALID_OUT(txv), .HOST_TX_READY_IN(rdy), .SER_RXD_IN(rxd), .SER_TXD_OUT(txd),
    .SER_RTS_OUT(rts), .SER_DTR_OUT(dtr), .EXTERNAL_TRIGGER_INPUT_IN(external_trigger_input),
    .MEAS_DATA_IN(md), .MEAS_DONE_IN(done), .MEAS_START_OUT(mst), .KEY_IN(key),
    .KEY_ENTER_IN(kent), .KEY_LOCAL_IN(kloc), .KEY_OUT(ko), .MENU_SHOWN_IN(menu),
    .SHOW_MEAS_OUT(shw), .REMOTE_INDICATOR_OUT(rem));
  hcp_host_model u_host (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
  // ****************
  // Clock, monitors and tasks
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (txv === 1'b1 && rdy === 1'b1) got.push_back(txdat);
    if (mst === 1'b1) starts++;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= ~w;
    @(posedge clk);
    while (wrq !== 1'b0) @(posedge clk);
    rdat = rdo;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task remote_on;
    usb_act <= 1'b1;
    tick(1);
    usb_act <= 1'b0;
    tick(1);
    chk({rem, shw}, 32'h3);
  endtask
  task tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Whole run needs well under this span
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
  // ****************
  // Test sequence
  // ****************
  initial
  begin
    {rd_s, wr_s, usb_act, bus_act, gtl, external_trigger_input, done, kent, kloc, menu} = '0;
    rst = 1'b1;
    rdy = 1'b1;
    adr = '0;
    wd = '0;
    md = '0;
    key = '0;
    bc = int'(hcp_pkg::DIV_115200);
    tick(4);
    rst <= 1'b0;
    tick(1);
    rd(hcp_pkg::OFS_CTRL, 32'h0);
    rd(hcp_pkg::OFS_BAUD, 32'h1);
    rd(hcp_pkg::OFS_ADDR, 32'h1);
    chk({ue, se, be, rts, dtr, dl, kb, ba}, 32'h981);
    wr(hcp_pkg::OFS_BAUD, 32'h5);
    rd(hcp_pkg::OFS_BAUD, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      wr(hcp_pkg::OFS_BAUD, 32'(i));
      rd(hcp_pkg::OFS_BAUD, 32'(i));
    end
    wr(hcp_pkg::OFS_ADDR, 32'h1F);
    rd(hcp_pkg::OFS_ADDR, 32'h1);
    wr(hcp_pkg::OFS_ADDR, 32'h0);
    rd(hcp_pkg::OFS_ADDR, 32'h0);
    wr(hcp_pkg::OFS_ADDR, 32'h1E);
    tick(1);
    chk(ba, 32'h1E);
    wr(hcp_pkg::OFS_CTRL, 32'h3);
    rd(hcp_pkg::OFS_CTRL, 32'h0);
    wr(hcp_pkg::OFS_CTRL, 32'h42);
    tick(1);
    chk({ue, se, be, dl}, 32'h3);
    bus_act <= 1'b1;
    tick(1);
    bus_act <= 1'b0;
    gtl <= 1'b1;
    tick(1);
    gtl <= 1'b0;
    chk(rem, 32'h1);
    tick(2);
    chk(rem, 32'h0);
    rd(5'h1C, 32'h0);
    wr(hcp_pkg::OFS_CTRL, 32'h4);
    tick(1);
    chk({ue, kb}, 32'h3);
    menu <= 1'b1;
    key <= 8'hFF;
    remote_on;
    tick(1);
    chk(ko, 32'h0);
    wr(hcp_pkg::OFS_CMD, 32'h1);
    tick(2);
    chk({rem, ko}, 32'hFF);
    remote_on;
    kloc <= 1'b1;
    tick(1);
    kloc <= 1'b0;
    tick(2);
    chk(rem, 32'h0);
    menu <= 1'b0;
    md <= 8'h3C;
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(6);
    chk(got.pop_front(), 32'h3C);
    wr(hcp_pkg::OFS_CTRL, 32'h1C);
    md <= 8'h5A;
    done <= 1'b1;
    tick(1);
    done <= 1'b0;
    tick(4);
    chk(got.size(), 32'h0);
    n = starts;
    external_trigger_input <= 1'b1;
    tick(6);
    chk(starts - n, 32'h1);
    chk(got.pop_front(), 32'h5A);
    kent <= 1'b1;
    tick(1);
    kent <= 1'b0;
    tick(4);
    chk(got.pop_front(), 32'h5A);
    wr(hcp_pkg::OFS_CTRL, 32'h3C);
    n = starts;
    external_trigger_input <= 1'b0;
    tick(6);
    chk(starts - n, 32'h1);
    got.delete();
    wr(hcp_pkg::OFS_CTRL, 32'h1);
    tick(1);
    chk({ue, se, be}, 32'h2);
    u_host.send_byte(8'hA5, bc);
    rd(hcp_pkg::OFS_RXD, 32'hA5);
    rd(hcp_pkg::OFS_STAT, 32'h9);
    fork
      wr(hcp_pkg::OFS_TXD, 32'h96);
      u_host.recv_byte(bc, b);
    join
    chk(b, 32'h96);
    wr(hcp_pkg::OFS_CMD, 32'h1);
    wr(hcp_pkg::OFS_CTRL, 32'h9);
    u_host.send_byte(8'h33, bc);
    rd(hcp_pkg::OFS_STAT, 32'h19);
    wr(hcp_pkg::OFS_CMD, 32'h1);
    wr(hcp_pkg::OFS_CTRL, 32'h0);
    rdy <= 1'b0;
    n = 0;
    bus(1'b0, hcp_pkg::OFS_STAT, 32'h0);
    while (rdat[2] === 1'b0 && n < 20)
    begin
      wr(hcp_pkg::OFS_TXD, 32'(n));
      n++;
      bus(1'b0, hcp_pkg::OFS_STAT, 32'h0);
    end
    chk(n >= 16 && n <= 17, 32'h1);
    rdy <= 1'b1;
    tick(40);
    chk(got.size(), 32'(n));
    chk(got[n - 1], 32'(n - 1));
    rd(hcp_pkg::OFS_STAT, 32'h8);
    tally_and_finish;
  end
endmodule
